// [core/serial_regs_pkg.sv]
// Shared constants and types for the serial register-access front end
package serial_regs_pkg;
  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_COMMAND      = 6'h00;
  localparam logic [5:0] ADDR_PORT_CFG     = 6'h01;
  localparam logic [5:0] ADDR_PART_ID      = 6'h02;
  localparam logic [5:0] ADDR_FACTORY_TEST = 6'h03;
  localparam logic [5:0] ADDR_READY_STATUS = 6'h04;
  localparam logic [5:0] ADDR_INTEGRITY    = 6'h05;
  localparam logic [5:0] ADDR_OFFSET_COEFF = 6'h06;
  localparam logic [5:0] ADDR_RESULT_A     = 6'h08;
  localparam logic [5:0] ADDR_RESULT_B     = 6'h0a;
  localparam logic [5:0] ADDR_MODE_A       = 6'h38;
  localparam logic [5:0] ADDR_MODE_B       = 6'h3a;

  // ---------------------------------------------------------------
  // Command byte fields
  // ---------------------------------------------------------------
  localparam int CMD_ZERO_BIT = 7;
  localparam int CMD_READ_BIT = 6;
  localparam int CMD_CHAN_BIT = 1;

  // ---------------------------------------------------------------
  // Port register fields and reset values
  // ---------------------------------------------------------------
  localparam int PIN_A_DATA_BIT   = 7;
  localparam int PIN_B_DATA_BIT   = 6;
  localparam int PIN_A_DIR_BIT    = 5;
  localparam int PIN_B_DIR_BIT    = 4;
  localparam int READY_POLICY_BIT = 3;
  localparam int SYNC_ENABLE_BIT  = 0;
  localparam logic [7:0] PORT_CFG_RESET = 8'h30;
  localparam logic [7:0] PORT_CFG_WMASK = 8'hf9;

  // Status bit positions
  localparam int PENDING_A_BIT = 0;
  localparam int PENDING_B_BIT = 2;
  localparam logic [7:0] READY_STATUS_RESET = 8'h00;

  // Coefficient and other resets
  localparam logic [23:0] OFFSET_COEFF_RESET = 24'h800000;
  localparam logic [23:0] TEST_RESET         = 24'h000000;
  localparam logic [15:0] INTEGRITY_RESET    = 16'h0000;
  localparam logic [3:0]  GENERIC_CODE       = 4'h5; // Arbitrary value

  // Recovery sequence length in serial clocks
  localparam logic [5:0] RECOVERY_CLOCKS = 6'd32;

  // Access widths in bits
  localparam logic [4:0] WIDTH_8  = 5'd8;
  localparam logic [4:0] WIDTH_16 = 5'd16;
  localparam logic [4:0] WIDTH_24 = 5'd24;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_COMMAND = 2'b00,
    PH_WRITE   = 2'b01,
    PH_READ    = 2'b10
  } phase_t;

  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic din;
    logic cs_n;
  } link_sample_t;

  typedef struct packed {
    logic        pulse;
    logic [5:0]  addr;
    logic [23:0] data;
  } reg_write_t;
endpackage : serial_regs_pkg

// [core/link_sampler.sv]
// Two-stage synchroniser and edge finder for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module link_sampler
  import serial_regs_pkg::*;
(
  // Clock and reset
  input  wire logic   CLK,
  input  wire logic   RESETN,
  // Raw pins
  input  wire logic   sclk_pin,
  input  wire logic   din_pin,
  input  wire logic   cs_n_pin,
  // Sampled view
  output link_sample_t smp
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic       sclk_old;
  } sampler_state_t;

  sampler_state_t s_q;
  sampler_state_t s_d;

  // Next state: meta stage only feeds sync stage
  always_comb begin
    s_d          = s_q;
    s_d.meta     = {sclk_pin, din_pin, cs_n_pin};
    s_d.sync     = s_q.meta;
    s_d.sclk_old = s_q.sync[2];
  end

  // Registers; chip select idles high
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s_q <= '{meta: 3'b001, sync: 3'b001, sclk_old: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Edges are judged only on the second stage
  assign smp.sclk_rise = s_q.sync[2] & ~s_q.sclk_old;
  assign smp.sclk_fall = ~s_q.sync[2] & s_q.sclk_old;
  assign smp.din       = s_q.sync[1];
  assign smp.cs_n      = s_q.sync[0];
endmodule : link_sampler
`default_nettype wire

// [core/ready_status.sv]
// Per-channel result-pending flags and the ready pin policy
`timescale 1ns/1ps
`default_nettype none
module ready_status
  import serial_regs_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // Events
  input  wire logic [1:0] load_pulse,
  input  wire logic [1:0] read_pulse,
  input  wire logic       mode_write,
  input  wire logic       cal_busy,
  input  wire logic       cal_done,
  // Policy
  input  wire logic       all_policy,
  input  wire logic [1:0] chan_enable,
  // Results
  output logic      [1:0] pending,
  output logic            ready_n
);
  typedef struct packed {
    logic [1:0] pend;
    logic [1:0] was_loaded;
  } rdy_state_t;

  rdy_state_t s_q;
  rdy_state_t s_d;

  // A load in the same cycle as a read wins, so pend ends high
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 2; i++) begin
      if (read_pulse[i]) begin
        s_d.pend[i] = 1'b0;
      end
      if (load_pulse[i]) begin
        s_d.was_loaded[i] = s_q.pend[i];
        s_d.pend[i]       = 1'b1;
      end
    end
    if (mode_write || cal_busy) begin
      s_d.pend = 2'b00;
    end
    if (cal_done) begin
      s_d.pend = 2'b11;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pending = s_q.pend;
  // Ready pin: any pending, or every enabled channel pending
  assign ready_n = all_policy ? ~((&(s_q.pend | ~chan_enable)) & (|chan_enable))
                              : ~(|s_q.pend);

  chk_read_clears: assert property (@(posedge CLK) disable iff (!RESETN)
    read_pulse[0] && !load_pulse[0] && !cal_done |=> !pending[0])
    else $error("read did not clear pending flag");
  chk_load_sets: assert property (@(posedge CLK) disable iff (!RESETN)
    load_pulse[1] && !mode_write && !cal_busy |=> pending[1])
    else $error("load did not set pending flag");
  chk_mode_clears: assert property (@(posedge CLK) disable iff (!RESETN)
    mode_write && !cal_done |=> pending == 2'b00)
    else $error("mode write did not clear status");
  chk_cal_done_sets: assert property (@(posedge CLK) disable iff (!RESETN)
    cal_done |=> pending == 2'b11)
    else $error("calibration end did not set status");
  chk_any_policy: assert property (@(posedge CLK) disable iff (!RESETN)
    !all_policy && pending != 2'b00 |-> !ready_n)
    else $error("ready pin not asserted with pending data");
  cov_cal_done: cover property (@(posedge CLK) disable iff (!RESETN) cal_done);
endmodule : ready_status
`default_nettype wire

// [core/serial_reg_bank.sv]
// Serial register-access front end with general-purpose registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - After reset and each completed access, the interface awaits a command byte.
// - Thirty-two clocks with data high and select low reset everything.
// - Command: bit 7 zero, bit 6 read flag, bits 5..0 address.
// - Address bit 1 selects channel; mode writes pick the channel too.
// - Port data bits drive output pins and read back input pins.
// - Direction bits 5 and 4: one means input; both reset to one.
// - Ready policy bit chooses any-pending or all-enabled-pending for ready pin.
// - Sync-enable bit 0 resets low; high gives the shared pin to sync.
// - Port register resets to 30h plus pin levels in data bits.
// - Identification returns revision in bits 7..4, generic code in 3..0.
// - A finished conversion updates the result and sets its pending flag.
// - Reading a channel result clears its pending flag.
// - Loading over an unread result leaves the flag set.
// - Any mode register write clears the whole status register.
// - Calibration holds status at zero, then sets both pending bits when done.
// - Status bit 0 is channel A, bit 2 channel B; resets to 00h.
// - Offset coefficient resets to 800000h, loaded by zero-scale self-calibration.
module serial_reg_bank
  import serial_regs_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h0 // Arbitrary value
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // Serial link
  input  wire logic        SCLK,
  input  wire logic        DIN,
  input  wire logic        CS_N,
  output logic             DOUT,
  output logic             DOUT_OE,
  // General-purpose pins
  input  wire logic        PIN_A_I,
  output logic             PIN_A_O,
  output logic             PIN_A_OE,
  input  wire logic        PIN_B_I,
  output logic             PIN_B_O,
  output logic             PIN_B_OE,
  output logic             SYNC_ENABLE,
  // Ready pin
  output logic             READY_N,
  // Conversion datapath
  input  wire logic [1:0]  RESULT_LOAD,
  input  wire logic [23:0] RESULT_A,
  input  wire logic [23:0] RESULT_B,
  input  wire logic [1:0]  CHAN_ENABLE,
  input  wire logic        CAL_BUSY,
  input  wire logic        CAL_DONE,
  input  wire logic        OFFSET_CAL_DONE,
  input  wire logic [23:0] OFFSET_CAL_VALUE,
  output logic             SYS_RESET,
  output reg_write_t       REG_WRITE,
  output logic             MODE_CHANNEL
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    phase_t      phase;
    logic [5:0]  addr;
    logic [4:0]  bit_cnt;
    logic [4:0]  width;
    logic [23:0] shift;
    logic [5:0]  ones_cnt;
    logic [7:0]  port_cfg;
    logic [23:0] test_reg;
    logic [15:0] integrity;
    logic [23:0] offset_coeff;
    logic        strap_pending;
    logic        dout;
    logic        dout_oe;
    logic        sys_reset;
    logic        mode_chan;
    reg_write_t  wr;
    logic [1:0]  rd_pulse;
    logic        mode_wr;
  } bank_state_t;

  bank_state_t  s_q;
  bank_state_t  s_d;
  link_sample_t smp;
  logic [1:0]   pin_meta_q;
  logic [1:0]   pin_sync_q;
  logic [1:0]   pending;
  logic [7:0]   status_byte;
  logic [7:0]   port_view;
  logic [7:0]   part_id;
  logic [23:0]  read_word;
  logic [4:0]   access_width;
  logic         ro_target;

  // -----------------------------------------------------------------
  // Pin sampling
  // -----------------------------------------------------------------
  link_sampler u_link (
    .CLK      (CLK),
    .RESETN   (RESETN),
    .sclk_pin (SCLK),
    .din_pin  (DIN),
    .cs_n_pin (CS_N),
    .smp      (smp)
  );

  // Port pins cross in through two flops; left running through reset so
  // the strap capture just after release sees real pin levels, not zeros
  always_ff @(posedge CLK) begin
    pin_meta_q <= {PIN_A_I, PIN_B_I};
    pin_sync_q <= pin_meta_q;
  end

  // -----------------------------------------------------------------
  // Read views
  // -----------------------------------------------------------------
  // Input pins read their level, output pins their driven bit
  always_comb begin
    port_view = s_q.port_cfg;
    if (s_q.port_cfg[PIN_A_DIR_BIT]) begin
      port_view[PIN_A_DATA_BIT] = pin_sync_q[1];
    end
    if (s_q.port_cfg[PIN_B_DIR_BIT]) begin
      port_view[PIN_B_DATA_BIT] = pin_sync_q[0];
    end
  end

  assign part_id = {REVISION, GENERIC_CODE};

  // Pending flags sit at their own bit positions
  always_comb begin
    status_byte                = READY_STATUS_RESET;
    status_byte[PENDING_A_BIT] = pending[0];
    status_byte[PENDING_B_BIT] = pending[1];
  end

  // Register width and source per address, MSB aligned at bit 23
  always_comb begin
    ro_target    = 1'b0;
    access_width = WIDTH_8;
    read_word    = '0;
    unique case (s_q.addr)
      ADDR_PORT_CFG: begin
        read_word = {port_view, 16'h0000};
      end
      ADDR_PART_ID: begin
        read_word = {part_id, 16'h0000};
        ro_target = 1'b1;
      end
      ADDR_FACTORY_TEST: begin
        read_word    = s_q.test_reg;
        access_width = WIDTH_24;
      end
      ADDR_READY_STATUS: begin
        read_word = {status_byte, 16'h0000};
        ro_target = 1'b1;
      end
      ADDR_INTEGRITY: begin
        read_word    = {s_q.integrity, 8'h00};
        access_width = WIDTH_16;
      end
      ADDR_OFFSET_COEFF: begin
        read_word    = s_q.offset_coeff;
        access_width = WIDTH_24;
      end
      ADDR_RESULT_A: begin
        read_word    = RESULT_A;
        access_width = WIDTH_24;
        ro_target    = 1'b1;
      end
      ADDR_RESULT_B: begin
        read_word    = RESULT_B;
        access_width = WIDTH_24;
        ro_target    = 1'b1;
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Serial engine
  // -----------------------------------------------------------------
  // Data is taken on rising clock, shifted out on falling clock
  always_comb begin
    s_d          = s_q;
    s_d.wr.pulse = 1'b0;
    s_d.rd_pulse = 2'b00;
    s_d.mode_wr  = 1'b0;
    s_d.sys_reset = 1'b0;

    // Pin levels are caught one cycle after reset release
    if (s_q.strap_pending) begin
      s_d.strap_pending                 = 1'b0;
      s_d.port_cfg[PIN_A_DATA_BIT]      = pin_sync_q[1];
      s_d.port_cfg[PIN_B_DATA_BIT]      = pin_sync_q[0];
    end

    // Deselect abandons any access half way
    if (smp.cs_n) begin
      s_d.phase    = PH_COMMAND;
      s_d.bit_cnt  = '0;
      s_d.dout_oe  = 1'b0;
      s_d.ones_cnt = '0; // Recovery ones only count while selected
    end else if (smp.sclk_rise) begin
      s_d.shift   = {s_q.shift[22:0], smp.din};
      s_d.bit_cnt = s_q.bit_cnt + 5'd1;
      s_d.ones_cnt = smp.din ? s_q.ones_cnt + 6'd1 : 6'd0;
      unique case (s_q.phase)
        PH_COMMAND: begin
          if (s_q.bit_cnt == 5'd7) begin
            s_d.bit_cnt = '0;
            s_d.addr    = {s_q.shift[4:0], smp.din};
            if (s_q.shift[6] != 1'b0) begin
              s_d.phase = PH_COMMAND; // Illegal top bit: stay put
            end else if (s_q.shift[5]) begin
              s_d.phase = PH_READ;
            end else begin
              s_d.phase = PH_WRITE;
            end
          end
        end
        PH_WRITE: begin
          if (s_q.bit_cnt == access_width - 5'd1) begin
            s_d.phase        = PH_COMMAND;
            s_d.bit_cnt      = '0;
            s_d.wr.pulse     = 1'b1;
            s_d.wr.addr      = s_q.addr;
            s_d.wr.data      = {s_q.shift[22:0], smp.din};
            s_d.mode_chan    = (s_q.addr == ADDR_MODE_A || s_q.addr == ADDR_MODE_B)
                               ? s_q.addr[CMD_CHAN_BIT] : s_q.mode_chan;
            s_d.mode_wr      = (s_q.addr == ADDR_MODE_A || s_q.addr == ADDR_MODE_B);
            if (!ro_target) begin
              unique case (s_q.addr)
                ADDR_PORT_CFG:     s_d.port_cfg = {s_q.shift[6:0], smp.din} & PORT_CFG_WMASK;
                ADDR_FACTORY_TEST: s_d.test_reg = {s_q.shift[22:0], smp.din};
                ADDR_INTEGRITY:    s_d.integrity = {s_q.shift[14:0], smp.din};
                ADDR_OFFSET_COEFF: s_d.offset_coeff = {s_q.shift[22:0], smp.din};
                default:           s_d.port_cfg = s_q.port_cfg;
              endcase
            end
          end
        end
        PH_READ: begin
          if (s_q.bit_cnt == access_width - 5'd1) begin
            s_d.phase   = PH_COMMAND;
            s_d.bit_cnt = '0;
            s_d.rd_pulse = {s_q.addr == ADDR_RESULT_B, s_q.addr == ADDR_RESULT_A};
          end
        end
        default: begin
          s_d.phase = PH_COMMAND;
        end
      endcase
      // Recovery sequence overrides everything
      if (smp.din && s_q.ones_cnt == RECOVERY_CLOCKS - 6'd1) begin
        s_d.sys_reset = 1'b1;
      end
    end else if (smp.sclk_fall) begin
      s_d.dout_oe = (s_q.phase == PH_READ);
      s_d.dout    = read_word[5'd23 - s_q.bit_cnt];
    end

    // Self-calibration loads the offset coefficient
    if (OFFSET_CAL_DONE) begin
      s_d.offset_coeff = OFFSET_CAL_VALUE;
    end
  end

  // Registers; recovery reset behaves as a full reset
  always_ff @(posedge CLK) begin
    if (!RESETN || s_q.sys_reset) begin
      s_q              <= '0;
      s_q.phase        <= PH_COMMAND;
      s_q.port_cfg     <= PORT_CFG_RESET;
      s_q.test_reg     <= TEST_RESET;
      s_q.integrity    <= INTEGRITY_RESET;
      s_q.offset_coeff <= OFFSET_COEFF_RESET;
      s_q.strap_pending <= 1'b1;
      s_q.sys_reset    <= 1'b0; // One-cycle pulse, never self-sustaining
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // Status flags
  // -----------------------------------------------------------------
  ready_status u_ready (
    .CLK         (CLK),
    .RESETN      (RESETN && !s_q.sys_reset),
    .load_pulse  (RESULT_LOAD),
    .read_pulse  (s_q.rd_pulse),
    .mode_write  (s_q.mode_wr),
    .cal_busy    (CAL_BUSY),
    .cal_done    (CAL_DONE),
    .all_policy  (s_q.port_cfg[READY_POLICY_BIT]),
    .chan_enable (CHAN_ENABLE),
    .pending     (pending),
    .ready_n     (READY_N)
  );

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign DOUT         = s_q.dout;
  assign DOUT_OE      = s_q.dout_oe;
  assign PIN_A_O      = s_q.port_cfg[PIN_A_DATA_BIT];
  assign PIN_A_OE     = ~s_q.port_cfg[PIN_A_DIR_BIT];
  assign PIN_B_O      = s_q.port_cfg[PIN_B_DATA_BIT];
  assign PIN_B_OE     = ~s_q.port_cfg[PIN_B_DIR_BIT] & ~s_q.port_cfg[SYNC_ENABLE_BIT];
  assign SYNC_ENABLE  = s_q.port_cfg[SYNC_ENABLE_BIT];
  assign SYS_RESET    = s_q.sys_reset;
  assign REG_WRITE    = s_q.wr;
  assign MODE_CHANNEL = s_q.mode_chan;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_recovery_reset: assert property (@(posedge CLK) disable iff (!RESETN)
    s_q.sys_reset |=> s_q.phase == PH_COMMAND && s_q.port_cfg == PORT_CFG_RESET
                      && s_q.offset_coeff == OFFSET_COEFF_RESET && !s_q.sys_reset)
    else $error("recovery did not reset registers");
  chk_deselect_idle: assert property (@(posedge CLK) disable iff (!RESETN)
    smp.cs_n |=> s_q.phase == PH_COMMAND)
    else $error("interface not back to command phase");
  chk_dir_enable: assert property (@(posedge CLK) disable iff (!RESETN)
    !$past(RESETN) |-> !PIN_A_OE && !PIN_B_OE)
    else $error("pins not inputs after reset");
  chk_zero_bits: assert property (@(posedge CLK) disable iff (!RESETN)
    s_q.port_cfg[2:1] == 2'b00)
    else $error("reserved port bits set");
  chk_ro_kept: assert property (@(posedge CLK) disable iff (!RESETN)
    s_q.wr.pulse && (s_q.wr.addr == ADDR_PART_ID || s_q.wr.addr == ADDR_READY_STATUS)
    |-> $stable(s_q.port_cfg) && $stable(s_q.offset_coeff) && $stable(s_q.test_reg))
    else $error("read-only write disturbed registers");
  cov_write: cover property (@(posedge CLK) s_q.wr.pulse);
  cov_read_done: cover property (@(posedge CLK) s_q.rd_pulse != 2'b00);
  cov_recovery: cover property (@(posedge CLK) s_q.sys_reset);
endmodule : serial_reg_bank
`default_nettype wire

// [verification/serial_host.sv]
// Host controller model driving the serial register link
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  // Serial link
  output var logic sclk,
  output var logic din,
  output var logic cs_n,
  input  wire logic dout
);
  logic [23:0] rd_data;
  event        rd_done;

  // Clock idles high and stands still between frames
  initial begin
    sclk = 1'b1;
    din  = 1'b1;
    cs_n = 1'b1;
  end

  // One link bit: data moves on the fall, device samples on the rise
  task automatic bit_cycle(input logic b, output logic s);
    sclk = 1'b0;
    din  = b;
    #160 sclk = 1'b1;
    #140 s = dout;
    #20;
  endtask : bit_cycle

  // Command byte then a data phase of the register's width
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd);
    logic s;
    rd_data = 24'h0;
    cs_n    = 1'b0;
    #160;
    for (int i = 7; i >= 0; i--) bit_cycle(cmd[i], s);
    for (int i = n - 1; i >= 0; i--) begin
      bit_cycle(cmd[6] ? 1'b0 : wd[i], s);
      rd_data[i] = s;
    end
    cs_n = 1'b1;
    din  = ~din; // Released line shows no stale level
    // Announce before waiting so the watcher reads rd_data before the next frame clears it
    if (cmd[6]) -> rd_done;
    #320;
  endtask : xfer

  // Recovery sequence: select low, data high for 32 clocks
  task automatic recover();
    logic s;
    cs_n = 1'b0;
    repeat (32) bit_cycle(1'b1, s);
    cs_n = 1'b1;
    din  = 1'b0;
    #640;
  endtask : recover
endmodule : serial_host
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the serial register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import serial_regs_pkg::*;
  logic        clk, resetn, pin_a_i, pin_b_i, cal_busy, cal_done, ocal_done;
  logic [1:0]  result_load, chan_enable;
  logic [23:0] result_a, result_b, ocal_value, exp_q[$];
  string       nm_q[$];
  int          n_errors, num_checks, seed, rnd, n_sysrst;
  wire logic   sys_rst;
  wire reg_write_t reg_wr;
  wire logic   sclk, din, cs_n, dout, dout_oe, pin_a_o, pin_a_oe, pin_b_o, pin_b_oe, sync_en, ready_n, mode_ch;

  serial_host host (.sclk(sclk), .din(din), .cs_n(cs_n), .dout(dout));
  serial_reg_bank #(.REVISION(4'h3)) DUT (.CLK(clk), .RESETN(resetn), .SCLK(sclk), .DIN(din), .CS_N(cs_n),
    .DOUT(dout), .DOUT_OE(dout_oe), .PIN_A_I(pin_a_i), .PIN_A_O(pin_a_o), .PIN_A_OE(pin_a_oe),
    .PIN_B_I(pin_b_i), .PIN_B_O(pin_b_o), .PIN_B_OE(pin_b_oe), .SYNC_ENABLE(sync_en), .READY_N(ready_n),
    .RESULT_LOAD(result_load), .RESULT_A(result_a), .RESULT_B(result_b), .CHAN_ENABLE(chan_enable),
    .CAL_BUSY(cal_busy), .CAL_DONE(cal_done), .OFFSET_CAL_DONE(ocal_done), .OFFSET_CAL_VALUE(ocal_value),
    .SYS_RESET(sys_rst), .REG_WRITE(reg_wr), .MODE_CHANNEL(mode_ch));

  // Recovery pulses counted on the falling edge, away from the launching edge
  always @(negedge clk) if (sys_rst === 1'b1) n_sysrst++;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  // Reads note their expectation; the watcher compares when data lands
  task automatic rd(string nm, logic [5:0] a, int n, logic [23:0] e);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    host.xfer({2'b01, a}, n, 24'h0);
  endtask : rd

  task automatic wr(logic [5:0] a, int n, logic [23:0] d);
    host.xfer({2'b00, a}, n, d);
  endtask : wr

  // Inputs move a fixed delay after the rising edge
  task automatic step();
    @(posedge clk);
    #2;
  endtask : step

  always @(host.rd_done) check(nm_q.pop_front(), host.rd_data, exp_q.pop_front());

  initial begin
    #2000000;
    n_errors++;
    summarize();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {resetn, cal_busy, cal_done, ocal_done, result_load, pin_b_i} = '0;
    {pin_a_i, chan_enable, seed} = {1'b1, 2'b11, 32'd91};
    rnd = $random(seed);
    {result_a, result_b, ocal_value} = {rnd[23:0], ~rnd[23:0], rnd[31:8]};
    repeat (20) step();
    resetn = 1'b1;
    repeat (4) step();
    rd("port", ADDR_PORT_CFG, 8, PORT_CFG_RESET | 8'h80);
    rd("ident", ADDR_PART_ID, 8, {4'h3, GENERIC_CODE});
    rd("status", ADDR_READY_STATUS, 8, READY_STATUS_RESET);
    rd("offset", ADDR_OFFSET_COEFF, 24, OFFSET_COEFF_RESET);
    wr(ADDR_PART_ID, 8, 24'hff);
    rd("ident_ro", ADDR_PART_ID, 8, {4'h3, GENERIC_CODE});
    check("dout_oe_idle", dout_oe, 24'h0);
    wr(ADDR_PORT_CFG, 8, 24'h88);
    rd("port_out", ADDR_PORT_CFG, 8, 24'h88);
    check("pin_oe", {pin_a_oe, pin_b_oe, pin_a_o, pin_b_o}, 24'he);
    // All-enabled policy keeps the pin high until both channels have data
    step();
    result_load = 2'b01;
    step();
    result_load = 2'b00;
    repeat (3) step();
    check("ready_all", ready_n, 24'h1);
    result_load = 2'b10;
    step();
    result_load = 2'b00;
    repeat (3) step();
    check("ready_all2", ready_n, 24'h0);
    rd("status_ab", ADDR_READY_STATUS, 8, 24'h05);
    rd("result_a", ADDR_RESULT_A, 24, result_a);
    rd("status_b", ADDR_READY_STATUS, 8, 24'h04);
    wr(ADDR_MODE_B, 8, 24'h0);
    check("mode_ch", mode_ch, 24'h1);
    check("wr_addr", 24'(reg_wr.addr), 24'(ADDR_MODE_B));
    rd("status_clr", ADDR_READY_STATUS, 8, 24'h0);
    wr(ADDR_PORT_CFG, 8, 24'h31);
    check("sync", {sync_en, pin_b_oe}, 24'h2);
    result_load = 2'b01;
    step();
    result_load = 2'b00;
    repeat (3) step();
    check("ready_any", ready_n, 24'h0);
    cal_busy = 1'b1;
    rd("cal_busy", ADDR_READY_STATUS, 8, 24'h0);
    cal_busy = 1'b0;
    cal_done = 1'b1;
    step();
    cal_done = 1'b0;
    rd("cal_done", ADDR_READY_STATUS, 8, 24'h05);
    wr(ADDR_OFFSET_COEFF, 24, rnd[31:8] ^ 24'h5a5a5a);
    check("wr_data", reg_wr.data, rnd[31:8] ^ 24'h5a5a5a);
    rd("offset_wr", ADDR_OFFSET_COEFF, 24, rnd[31:8] ^ 24'h5a5a5a);
    ocal_done = 1'b1;
    step();
    ocal_done = 1'b0;
    rd("offset_cal", ADDR_OFFSET_COEFF, 24, ocal_value);
    host.recover();
    check("sys_reset", 24'(n_sysrst), 24'h1);
    rd("port_rec", ADDR_PORT_CFG, 8, PORT_CFG_RESET | 8'h80);
    rd("offset_rec", ADDR_OFFSET_COEFF, 24, OFFSET_COEFF_RESET);
    summarize();
  end
endmodule : testbench
`default_nettype wire
